// file: src/link_power_mode_control.sv
// Purpose: operating-mode sequencer of the byte link controller
// Assumes: cpu instruction strobes and reset sources synchronous to ref_clk_in
// Notes:   link_clock_run_out gates the link clock; registers sit on AHB-Lite
`timescale 1ns/1ps
`include "link_power_regs.svh"

// Behaviour
// - any reset source forces reset mode from every other mode
// - reset mode holds registers and outputs at reset, ignores inputs, clock runs
// - reset mode leaves for run only once all reset sources release
// - mode select 0 plus cpu wait enters link wait mode
// - wait mode never drives the network; link clock keeps running
// - first network rise in wait raises interrupt, wakes, message received
// - mode select 1 plus cpu wait enters stop, link clock stopped
// - mode select 1 plus cpu stop enters stop with cpu also stopped
// - first network rise in stop raises non-maskable interrupt, vector 20 hex
// - stop wakeup appears in state vector as highest priority source
// - wakeup from wait or stop resets no register
// - stop wakeup returns to run; reception may lag until clocks settle
// - after full stop the waking message is not guaranteed received
// - with a loopback bit set, low power modes ignore network traffic
// - wake and reception identical in normal and 4x receive modes
// - digital loopback ties transmit to receive internally, network undriven
module link_power_mode_control (
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        reset_source_in,
    input  wire logic        cpu_wait_exec_in,
    input  wire logic        cpu_stop_exec_in,
    input  wire logic        protocol_tx_in,
    input  wire logic        frame_eof_in,
    input  wire logic        link_receive_pin_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic             link_transmit_pin_out,
    output logic             protocol_rx_out,
    output logic             rx_4x_mode_out,
    output logic             analog_loopback_out,
    output logic             link_clock_run_out,
    output logic             clock_restart_req_out,
    output logic             cpu_irq_out,
    output logic             cpu_nmi_out
);

    link_power_pkg::mode_t     mode;
    link_power_pkg::ctrl_t     ctrl;
    link_power_pkg::sv_flags_t sv_flags;

    logic       in_reset;
    logic       low_power;
    logic       stop_mode;
    logic       detach;
    logic       wake;
    logic       addr_valid;
    logic       wr_pending;
    logic [7:0] wr_addr;
    logic       sv_read;
    logic [7:0] sv_code;
    logic [7:0] settle_cnt;
    logic       settling;
    logic [31:0] next_rdata;

    // reset mode covers the synchronous sources and the cycle of reset state
    assign in_reset  = reset_source_in || (mode == link_power_pkg::MODE_RESET);
    assign low_power = (mode == link_power_pkg::MODE_WAIT) || stop_mode;
    assign stop_mode = (mode == link_power_pkg::MODE_STOP_CWT) ||
                       (mode == link_power_pkg::MODE_STOP_CSTP);
    // a loopback bit disarms wakeup entirely
    assign detach    = ctrl.analog_loopback_bit || ctrl.digital_loopback_bit;
    assign settling  = (settle_cnt != 8'h00);

    // the detector stays disarmed in run and reset mode, so ordinary traffic
    // never leaves a stale arm behind for the next low-power entry
    // detector sees only the pin, the mode and the loopback bits, never the 4x bit
    wake_detector u_wake_detector (
        .ref_clk_in (ref_clk_in),
        .arst_n_in  (arst_n_in),
        .enable_in  (low_power && !detach),
        .rx_pin_in  (link_receive_pin_in),
        .wake_out   (wake)
    );

    // async restart request for the gated link clock
    assign clock_restart_req_out = wake && stop_mode;

    // strobes outside run mode are ignored: a stray strobe in reset or in a
    // low-power mode must not move the sequencer
    // mode sequencing
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode <= link_power_pkg::MODE_RESET;
        end else if (reset_source_in) begin
            mode <= link_power_pkg::MODE_RESET;
        end else begin
            unique case (mode)
                link_power_pkg::MODE_RESET: begin
                    mode <= link_power_pkg::MODE_RUN;
                end
                link_power_pkg::MODE_RUN: begin
                    if (cpu_wait_exec_in && !ctrl.wake_clock_mode_select) begin
                        mode <= link_power_pkg::MODE_WAIT;
                    end else if (cpu_wait_exec_in) begin
                        mode <= link_power_pkg::MODE_STOP_CWT;
                    end else if (cpu_stop_exec_in && ctrl.wake_clock_mode_select) begin
                        mode <= link_power_pkg::MODE_STOP_CSTP;
                    end
                end
                link_power_pkg::MODE_WAIT,
                link_power_pkg::MODE_STOP_CWT,
                link_power_pkg::MODE_STOP_CSTP: begin
                    if (wake) begin
                        mode <= link_power_pkg::MODE_RUN;
                    end
                end
                default: begin
                    mode <= link_power_pkg::MODE_RESET;
                end
            endcase
        end
    end

    // limitation: this is only the enable level; glitch-free switching of the
    // link clock is left to the gate cell that consumes it
    // link clock gate: runs in reset, run and wait, stops in stop modes
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_clock_run_out <= 1'b1;
        end else if (in_reset) begin
            link_clock_run_out <= 1'b1;
        end else if (stop_mode && !wake) begin
            link_clock_run_out <= 1'b0;
        end else begin
            link_clock_run_out <= 1'b1;
        end
    end

    // trade-off: a fixed count instead of a lock indicator keeps oscillator
    // details out of this block; the count must cover the slowest start-up
    // oscillator settle after a full stop; the waking frame is dropped meanwhile
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            settle_cnt <= 8'h00;
        end else if (in_reset) begin
            settle_cnt <= 8'h00;
        end else if (mode == link_power_pkg::MODE_STOP_CSTP && wake) begin
            settle_cnt <= 8'(`OSC_SETTLE_CYCLES);
        end else if (settling) begin
            settle_cnt <= settle_cnt - 8'h01;
        end
    end

    // pulses, not levels: the cpu side latches them, so no clear path is needed
    // interrupt pulses, one cycle each, on the waking transition
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cpu_irq_out <= 1'b0;
            cpu_nmi_out <= 1'b0;
        end else if (in_reset) begin
            cpu_irq_out <= 1'b0;
            cpu_nmi_out <= 1'b0;
        end else begin
            cpu_irq_out <= wake && (mode == link_power_pkg::MODE_WAIT);
            cpu_nmi_out <= wake && stop_mode;
        end
    end

    // both pins are registered: one cycle of latency buys freedom from
    // glitches of the mode decode on the network side
    // network pins: transmit undriven outside run and in digital loopback
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_transmit_pin_out <= 1'b0;
            protocol_rx_out       <= 1'b0;
        end else if (in_reset) begin
            link_transmit_pin_out <= 1'b0;
            protocol_rx_out       <= 1'b0;
        end else begin
            link_transmit_pin_out <= (mode == link_power_pkg::MODE_RUN) &&
                                     !ctrl.digital_loopback_bit && protocol_tx_in;
            if (ctrl.digital_loopback_bit) begin
                protocol_rx_out <= protocol_tx_in;
            end else begin
                // wait mode passes the pin so the waking frame arrives whole
                protocol_rx_out <= !settling && link_receive_pin_in;
            end
        end
    end

    // mirror control bits to the protocol handler
    assign rx_4x_mode_out      = ctrl.rx_4x_mode;
    assign analog_loopback_out = ctrl.analog_loopback_bit;

    // only haddr[7:0] is decoded, so the register set aliases every 256 bytes;
    // hsize is ignored because every access is a whole word
    // ahb-lite: zero wait states, always okay
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign addr_valid    = hsel_in && htrans_in[1] && hready_in;
    assign sv_read       = addr_valid && !hwrite_in &&
                           (haddr_in[7:0] == `LINK_STATE_VECTOR_OFFSET);

    // address phase capture of a write
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_pending <= 1'b0;
            wr_addr    <= 8'h00;
        end else begin
            wr_pending <= addr_valid && hwrite_in;
            wr_addr    <= haddr_in[7:0];
        end
    end

    // control register; held at reset in reset mode, untouched by wakeup
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl <= `CTRL_RESET;
        end else if (in_reset) begin
            ctrl <= `CTRL_RESET;
        end else if (wr_pending && (wr_addr == `LINK_CONTROL_ONE_OFFSET)) begin
            ctrl.wake_clock_mode_select <= hwdata_in[`WAKE_CLOCK_MODE_SELECT_BIT];
            ctrl.analog_loopback_bit    <= hwdata_in[`ANALOG_LOOPBACK_BIT];
            ctrl.digital_loopback_bit   <= hwdata_in[`DIGITAL_LOOPBACK_BIT];
            ctrl.rx_4x_mode             <= hwdata_in[`RX4X_BIT];
        end
        // no wakeup term here, so contents survive it
    end

    // state vector code, wakeup first
    always_comb begin
        if (sv_flags.wake) begin
            sv_code = `SV_WAKE;
        end else if (sv_flags.eof) begin
            sv_code = `SV_EOF;
        end else begin
            sv_code = `SV_NONE;
        end
    end

    // a wake that lands on the reading edge must not be lost, hence set wins
    // sticky sources; a read clears the one shown, a same-cycle set wins
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sv_flags <= 2'b00;
        end else if (in_reset) begin
            sv_flags <= 2'b00;
        end else begin
            if (wake && stop_mode) begin
                sv_flags.wake <= 1'b1;
            end else if (sv_read && sv_flags.wake) begin
                sv_flags.wake <= 1'b0;
            end
            // eof clears on read only when no wake is shown, so it follows the wake
            if (frame_eof_in) begin
                sv_flags.eof <= 1'b1;
            end else if (sv_read && !sv_flags.wake) begin
                sv_flags.eof <= 1'b0;
            end
        end
    end

    // reads have no side effect except on the state vector, which clears on read
    // read mux, registered into the data phase
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (addr_valid && !hwrite_in) begin
            unique case (haddr_in[7:0])
                `LINK_CONTROL_ONE_OFFSET: begin
                    next_rdata[3:0] = ctrl;
                end
                `LINK_STATE_VECTOR_OFFSET: begin
                    next_rdata[7:0] = sv_code;
                end
                `MODE_STATUS_OFFSET: begin
                    next_rdata[`STATUS_MODE_LSB +: 3] = mode;
                    next_rdata[`STATUS_CLK_RUN_BIT]   = link_clock_run_out;
                    next_rdata[`STATUS_SETTLE_BIT]    = settling;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // read data stays put between transfers
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (addr_valid && !hwrite_in) begin
            hrdata_out <= next_rdata;
        end
    end

endmodule

// file: src/link_power_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit register words on an AHB-Lite slave, 100 MHz ref clock
// Notes:   definitions only
`ifndef LINK_POWER_REGS_SVH
`define LINK_POWER_REGS_SVH

// register byte offsets, decoded on haddr[7:0]
`define LINK_CONTROL_ONE_OFFSET  8'h00
`define LINK_STATE_VECTOR_OFFSET 8'h04
`define MODE_STATUS_OFFSET       8'h08

// link_control_one field positions
`define WAKE_CLOCK_MODE_SELECT_BIT 0
`define ANALOG_LOOPBACK_BIT        1
`define DIGITAL_LOOPBACK_BIT       2
`define RX4X_BIT                 3
`define CTRL_RESET               4'h0

// state vector codes, wakeup outranks end of frame
`define SV_NONE                  8'h00
`define SV_EOF                   8'h04
`define SV_WAKE                  8'h20

// mode status field positions
`define STATUS_MODE_LSB          0
`define STATUS_CLK_RUN_BIT       4
`define STATUS_SETTLE_BIT        5

// oscillator settle after a full stop, time and derived cycles
`define CLK_PERIOD_NS            10
`define OSC_SETTLE_NS            2000
`define OSC_SETTLE_CYCLES        ((`OSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: src/link_power_pkg.sv
// Purpose: shared types of the link power mode controller
// Assumes: nothing beyond the regs header
// Notes:   nothing is imported; users write link_power_pkg::name
package link_power_pkg;

    // operating modes of the link controller
    typedef enum logic [2:0] {
        MODE_RESET     = 3'b000,
        MODE_RUN       = 3'b001,
        MODE_WAIT      = 3'b010,
        MODE_STOP_CWT  = 3'b011,
        MODE_STOP_CSTP = 3'b100
    } mode_t;

    // software-written control word
    typedef struct packed {
        logic rx_4x_mode;
        logic digital_loopback_bit;
        logic analog_loopback_bit;
        logic wake_clock_mode_select;
    } ctrl_t;

    // pending state vector sources
    typedef struct packed {
        logic wake;
        logic eof;
    } sv_flags_t;

endpackage

// file: src/wake_detector.sv
// Purpose: passive-to-active detector that restarts stopped link clocks
// Assumes: network active level is 1 on the receive pin
// Notes:   wake_out is combinational so it works with the link clock stopped
`timescale 1ns/1ps
`include "link_power_regs.svh"

module wake_detector (
    input  wire logic ref_clk_in,
    input  wire logic arst_n_in,
    input  wire logic enable_in,
    input  wire logic rx_pin_in,
    output logic      wake_out
);

    logic armed;

    // arm only after passive is seen, so an active bus at entry is not a wake
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            armed <= 1'b0;
        end else if (!enable_in) begin
            armed <= 1'b0;
        end else if (!rx_pin_in) begin
            armed <= 1'b1;
        end
    end

    // restart request needs no clock edge once armed
    assign wake_out = enable_in & armed & rx_pin_in;

endmodule

// file: dv/link_power_mode_control_sva.sv
// Purpose: port-level checks of the link power mode controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound into every controller instance
`timescale 1ns/1ps
module link_power_mode_control_sva (
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    input wire logic reset_source_in,
    input wire logic cpu_wait_exec_in,
    input wire logic cpu_stop_exec_in,
    input wire logic protocol_tx_in,
    input wire logic link_transmit_pin_out,
    input wire logic link_clock_run_out,
    input wire logic clock_restart_req_out,
    input wire logic cpu_irq_out,
    input wire logic cpu_nmi_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);

    // reset source puts the link clock enable and both interrupts back to their resting level
    a_src_reset_out: assert property (reset_source_in |=> link_clock_run_out
        && !cpu_irq_out && !cpu_nmi_out) else $error("reset source left outputs active");
    a_tx_from_proto: assert property (link_transmit_pin_out |-> $past(protocol_tx_in))
        else $error("transmit pin driven without a transmit bit");
    a_irq_one_cycle: assert property (cpu_irq_out |=> !cpu_irq_out)
        else $error("wait wake interrupt longer than one cycle");
    a_nmi_one_cycle: assert property (cpu_nmi_out |=> !cpu_nmi_out)
        else $error("stop wake interrupt longer than one cycle");
    a_irq_nmi_excl: assert property (!(cpu_irq_out && cpu_nmi_out))
        else $error("both wake interrupts at once");
    // the asynchronous restart request must turn into the stop wake interrupt
    a_restart_to_nmi: assert property (clock_restart_req_out && !reset_source_in
        |=> cpu_nmi_out) else $error("restart request without stop wake interrupt");
    a_clock_stop_cause: assert property ($fell(link_clock_run_out)
        |-> $past(cpu_wait_exec_in || cpu_stop_exec_in, 2))
        else $error("link clock stopped without a cpu instruction");
    a_wake_clock_on: assert property ((cpu_irq_out || cpu_nmi_out)
        |-> link_clock_run_out) else $error("wake without link clock running");

    c_irq: cover property (cpu_irq_out);
    c_nmi: cover property (cpu_nmi_out);
    c_stop: cover property ($fell(link_clock_run_out));
    c_restart: cover property (clock_restart_req_out);
endmodule

bind link_power_mode_control link_power_mode_control_sva u_sva (
    .ref_clk_in            (ref_clk_in),
    .arst_n_in             (arst_n_in),
    .reset_source_in       (reset_source_in),
    .cpu_wait_exec_in      (cpu_wait_exec_in),
    .cpu_stop_exec_in      (cpu_stop_exec_in),
    .protocol_tx_in        (protocol_tx_in),
    .link_transmit_pin_out (link_transmit_pin_out),
    .link_clock_run_out    (link_clock_run_out),
    .clock_restart_req_out (clock_restart_req_out),
    .cpu_irq_out           (cpu_irq_out),
    .cpu_nmi_out           (cpu_nmi_out)
);

// file: dv/net_xcvr_model.sv
// Purpose: network and transceiver seen from the receive pin
// Assumes: passive bus reads 0, active reads 1
// Notes:   echoes the node's own transmit like a real transceiver
`timescale 1ns/1ps
module net_xcvr_model (
    input  wire logic ref_clk_in,
    input  wire logic tx_pin_in,
    output logic      rx_pin_out
);
    logic bus_active = 1'b0;

    // idle bus sits passive, so wakes always see a passive-to-active edge
    assign rx_pin_out = bus_active | tx_pin_in;

    // another node starts a frame: active for n cycles, then passive
    task automatic frame_start(input int n);
        @(posedge ref_clk_in);
        bus_active <= 1'b1;
        repeat (n) @(posedge ref_clk_in);
        bus_active <= 1'b0;
    endtask
endmodule

// file: dv/link_power_mode_control_tb_top.sv
// Purpose: self-checking bench of the link power mode controller
// Assumes: single-cycle AHB-Lite slave, wake by network model
// Notes:   seed fixed, so every run repeats
`timescale 1ns/1ps
module link_power_mode_control_tb_top;
    logic        ref_clk_in, arst_n_in, reset_source_in, cpu_wait_exec_in, cpu_stop_exec_in;
    logic        protocol_tx_in, frame_eof_in, hwrite_in, rx_pin, hreadyout_out, hresp_out;
    logic        link_transmit_pin_out, protocol_rx_out, rx_4x_mode_out, analog_loopback_out;
    logic        link_clock_run_out, clock_restart_req_out, cpu_irq_out, cpu_nmi_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd, r;
    logic [1:0]  htrans_in;
    logic [3:0]  ctl;
    logic [2:0]  m;
    int          mismatches = 0, num_checks = 0, seed = 13890, n;
    localparam logic [2:0] run_m = link_power_pkg::MODE_RUN;
    localparam logic [2:0] cstp_m = link_power_pkg::MODE_STOP_CSTP;
    localparam logic [2:0] wait_m = link_power_pkg::MODE_WAIT;

    link_power_mode_control uut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
        .reset_source_in(reset_source_in), .cpu_wait_exec_in(cpu_wait_exec_in),
        .cpu_stop_exec_in(cpu_stop_exec_in), .protocol_tx_in(protocol_tx_in),
        .frame_eof_in(frame_eof_in), .link_receive_pin_in(rx_pin), .hsel_in(1'b1),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .link_transmit_pin_out(link_transmit_pin_out), .protocol_rx_out(protocol_rx_out),
        .rx_4x_mode_out(rx_4x_mode_out), .analog_loopback_out(analog_loopback_out),
        .link_clock_run_out(link_clock_run_out), .clock_restart_req_out(clock_restart_req_out),
        .cpu_irq_out(cpu_irq_out), .cpu_nmi_out(cpu_nmi_out));
    net_xcvr_model net (.ref_clk_in(ref_clk_in), .tx_pin_in(link_transmit_pin_out),
        .rx_pin_out(rx_pin));

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            mismatches++;
        end
    endtask

    // bounded wait on hready (0), wait wake (1) or stop wake (2)
    task automatic wait_for(input int sel);
        logic [2:0] v;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
            v = {cpu_nmi_out, cpu_irq_out, hreadyout_out};
        end while (v[sel] !== 1'b1 && n < 64);
        if (n >= 64) begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    // one word transfer; read data taken at the edge ending the data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans_in <= 2'h2;
        haddr_in <= {24'h000000, a};
        hwrite_in <= wr;
        wait_for(0);
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        wait_for(0);
        rd = hrdata_out;
        chk("hresp", 32'h0, 32'(hresp_out));
    endtask

    // expected mode status word: clock bit set for run and wait only
    function automatic logic [31:0] exp_status(input logic [2:0] md, input logic settle);
        return {26'h0000000, settle, md <= wait_m && md != 3'h0, 1'b0, md};
    endfunction

    task automatic strobe(input logic stp);
        if (stp) cpu_stop_exec_in <= 1'b1;
        else cpu_wait_exec_in <= 1'b1;
        @(posedge ref_clk_in);
        cpu_stop_exec_in <= 1'b0;
        cpu_wait_exec_in <= 1'b0;
    endtask

    initial begin
        {arst_n_in, reset_source_in, cpu_wait_exec_in, cpu_stop_exec_in} = 4'h0;
        {protocol_tx_in, frame_eof_in, hwrite_in, htrans_in} = 5'h00;
        haddr_in = 32'h0;
        hwdata_in = 32'h0;
        repeat (10) @(posedge ref_clk_in);
        chk("reset_clock", 32'h1, 32'(link_clock_run_out));
        arst_n_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        bus(1'b0, 8'h00, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        bus(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b0, 8'h08, 32'h0);
        chk("run_after_reset", exp_status(run_m, 1'b0), rd);
        $display("test reset done");
        // every low-power mode, random receive speed and transmit bit
        for (int i = 0; i < 6; i++) begin
            m = 3'(2 + i % 3);
            r = $random(seed);
            ctl = {r[0], 2'h0, m != wait_m};
            bus(1'b1, 8'h00, {28'h0000000, ctl});
            frame_eof_in <= 1'b1;
            @(posedge ref_clk_in);
            frame_eof_in <= 1'b0;
            bus(1'b0, 8'h04, 32'h0);
            chk("eof_vector", 32'h4, rd);
            strobe(m == cstp_m);
            protocol_tx_in <= r[1];
            repeat (3) @(posedge ref_clk_in);
            chk("tx_quiet", 32'h0, 32'(link_transmit_pin_out));
            bus(1'b0, 8'h08, 32'h0);
            chk("mode_entered", exp_status(m, 1'b0), rd);
            protocol_tx_in <= 1'b0;
            fork
                net.frame_start(20);
            join_none
            wait_for(m == wait_m ? 1 : 2);
            chk("wake_irq_kind", 32'(m == wait_m), 32'(cpu_irq_out));
            @(posedge ref_clk_in);
            chk("rx_on_wake", 32'(m != cstp_m), 32'(protocol_rx_out));
            bus(1'b0, 8'h04, 32'h0);
            chk("wake_vector", m == wait_m ? 32'h0 : 32'h20, rd);
            bus(1'b0, 8'h00, 32'h0);
            chk("ctrl_kept", {28'h0000000, ctl}, rd);
            chk("rx4x_pin", 32'(ctl[3]), 32'(rx_4x_mode_out));
            bus(1'b0, 8'h08, 32'h0);
            chk("mode_woken", exp_status(run_m, m == cstp_m), rd);
            repeat (220) @(posedge ref_clk_in);
            $display("test low power mode %0d done", m);
        end
        // detached by analog then digital loopback: traffic never wakes
        for (int k = 1; k < 3; k++) begin
            bus(1'b0, 8'h04, 32'h0);
            chk("flags_clear", 32'h0, rd);
            bus(1'b1, 8'h00, 32'(2 * k));
            protocol_tx_in <= 1'b1;
            repeat (3) @(posedge ref_clk_in);
            chk("analog_loopback_bit_pin", 32'(k == 1), 32'(analog_loopback_out));
            chk("loop_rx", 32'h1, 32'(protocol_rx_out));
            chk("loop_tx", 32'(k == 1), 32'(link_transmit_pin_out));
            protocol_tx_in <= 1'b0;
            repeat (3) @(posedge ref_clk_in);
            strobe(1'b0);
            net.frame_start(20);
            bus(1'b0, 8'h08, 32'h0);
            chk("detached_sleeps", exp_status(wait_m, 1'b0), rd);
            reset_source_in <= 1'b1;
            @(posedge ref_clk_in);
            reset_source_in <= 1'b0;
            bus(1'b0, 8'h00, 32'h0);
            chk("ctrl_cleared", 32'h0, rd);
            bus(1'b0, 8'h08, 32'h0);
            chk("run_again", exp_status(run_m, 1'b0), rd);
            $display("test loopback %0d done", k);
        end
        tally_and_finish();
    end
endmodule
